// >>> hdl/tic_map.svh
// Register offsets, field positions, codes and reset values of the timer
//
// Notes on behaviour
// - With filter on, output changes only after four equal consecutive samples.
// - Filter adds four core clock cycles between input change and capture.
// - Edge select zero captures on falling edge, one on rising edge.
// - Each capture event copies the counter into capture register, sets flag.
// - Capture source is the capture pin, or optionally the comparator output.
// - While capture register is top value, the capture input is ignored.
// - Mode bit zero: top 0xFFFF; one: top is capture register.
// - Clock select: 000 stop, 001 every cycle, 110/111 external falling/rising.
// - External pin edges count even when that pin is an output.
// - Counter and capture words move through one shared high byte latch.
// - Counter write removes compare match on the following timer tick.
// - Capture interrupt needs enable bit, global enable and capture flag.
// - Overflow interrupt needs enable bit, global enable and overflow flag.
// - Unused bits of mask and flag registers read as zero.
// - In clear-on-match mode, reaching top sets the capture flag.
// - Capture flag clears on vector execution or writing one to it.
// - Overflow flag clears on vector execution or writing one to it.
// - Normal mode counts up, wraps to zero, flags overflow then.
// - Clear-on-match resets counter at capture value; top not double buffered.
// - Low byte read latches high byte; high byte read returns latch.
`ifndef TIC_MAP_SVH
`define TIC_MAP_SVH

`define TIC_A_CTRL 3'h0
`define TIC_A_CNT_LO 3'h1
`define TIC_A_CNT_HI 3'h2
`define TIC_A_CAP_LO 3'h3
`define TIC_A_CAP_HI 3'h4
`define TIC_A_MASK 3'h5
`define TIC_A_FLAGS 3'h6

`define TIC_B_NF 7
`define TIC_B_EDGE 6
`define TIC_B_WGM 4
`define TIC_F_CS 2:0
`define TIC_B_CIE 5
`define TIC_B_OIE 0
`define TIC_B_CF 5
`define TIC_B_OF 0

`define TIC_CTRL_WMASK 8'hd7
`define TIC_MASK_WMASK 8'h21

`define TIC_CS_STOP 3'h0
`define TIC_CS_IO 3'h1
`define TIC_CS_EXT_FALL 3'h6
`define TIC_CS_EXT_RISE 3'h7

`define TIC_TOP_MAX 16'hffff
`define TIC_RST_CTRL 8'h00
`define TIC_RST_MASK 8'h00
`define TIC_RST_WORD 16'h0000
`define TIC_FILT_LEN 4

`endif

// >>> hdl/tic_pkg.sv
// Types shared by the timer and its bench
`include "tic_map.svh"
package tic_pkg;

    typedef struct packed {
        logic re;
        logic we;
        logic [2:0] addr;
        logic [7:0] wdata;
    } tic_io_req_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic cflag;
        logic oflag;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic [7:0] temp;
        logic [`TIC_FILT_LEN-1:0] hist;
        logic filt;
        logic edge_prev;
        logic ext_prev;
        logic block;
        logic [7:0] rdata;
        logic irq_c;
        logic irq_o;
    } tic_state_t;

endpackage

// >>> hdl/tic_timer.sv
// Sixteen bit timer with input capture, noise filter and byte latch
`timescale 1ns/1ps
`include "tic_map.svh"
module tic_timer (
    input logic core_clk,
    input logic rstn,
    input tic_pkg::tic_io_req_t io_req,
    output logic [7:0] io_rdata,
    input logic global_irq_en,
    input logic capture_ack,
    input logic overflow_ack,
    input logic capture_input_pin,
    input logic acomp_out,
    input logic acomp_capture_sel,
    input logic external_count_pin,
    output logic capture_irq,
    output logic overflow_irq,
    output logic compare_block
);
    import tic_pkg::*;

    tic_state_t r;
    tic_state_t n;
    logic tick;
    logic src;
    logic cur;
    logic hist_eq;
    logic edge_hit;
    logic cap_evt;
    logic clear_on_match_mode;
    logic wr_cnt;
    logic wr_cap;
    logic top_hit;
    logic ovf_hit;
    logic cf_clr;
    logic of_clr;
    logic [2:0] cs;
    logic [7:0] cnt_hi;
    logic [7:0] rd;

    assign cs = r.ctrl[`TIC_F_CS];
    assign clear_on_match_mode = r.ctrl[`TIC_B_WGM];
    assign cnt_hi = r.cnt[15:8];

    // Timer tick; pin is read whatever its port direction
    always_comb begin
        case (cs)
            `TIC_CS_IO: tick = 1'h1;
            `TIC_CS_EXT_FALL: tick = r.ext_prev & ~external_count_pin;
            `TIC_CS_EXT_RISE: tick = ~r.ext_prev & external_count_pin;
            default: tick = 1'h0;
        endcase
    end

    assign src = acomp_capture_sel ? acomp_out : capture_input_pin;
    assign hist_eq = (&r.hist) | ~(|r.hist);
    assign cur = r.ctrl[`TIC_B_NF] ? r.filt : r.hist[0];
    assign edge_hit = r.ctrl[`TIC_B_EDGE] ? (cur & ~r.edge_prev)
                                          : (~cur & r.edge_prev);
    assign cap_evt = edge_hit & ~clear_on_match_mode;

    assign wr_cnt = io_req.we && io_req.addr == `TIC_A_CNT_LO;
    assign wr_cap = io_req.we && io_req.addr == `TIC_A_CAP_LO;
    assign top_hit = tick & clear_on_match_mode & (r.cnt == r.cap) & ~wr_cnt;
    assign ovf_hit = tick & (r.cnt == `TIC_TOP_MAX) & ~wr_cnt;

    assign cf_clr = capture_ack | (io_req.we &&
        io_req.addr == `TIC_A_FLAGS && io_req.wdata[`TIC_B_CF]);
    assign of_clr = overflow_ack | (io_req.we &&
        io_req.addr == `TIC_A_FLAGS && io_req.wdata[`TIC_B_OF]);

    // Read mux; unused bits stay zero
    always_comb begin
        rd = 8'h00;
        case (io_req.addr)
            `TIC_A_CTRL: rd = r.ctrl;
            `TIC_A_CNT_LO: rd = r.cnt[7:0];
            `TIC_A_CNT_HI: rd = r.temp;
            `TIC_A_CAP_LO: rd = r.cap[7:0];
            `TIC_A_CAP_HI: rd = r.temp;
            `TIC_A_MASK: rd = r.mask & `TIC_MASK_WMASK;
            `TIC_A_FLAGS: begin
                rd[`TIC_B_CF] = r.cflag;
                rd[`TIC_B_OF] = r.oflag;
            end
            default: rd = 8'h00;
        endcase
    end

    always_comb begin
        n = r;
        n.hist = {r.hist[`TIC_FILT_LEN-2:0], src};
        if (hist_eq) begin
            n.filt = r.hist[0];
        end
        n.edge_prev = cur;
        n.ext_prev = external_count_pin;

        if (io_req.re) begin
            n.rdata = rd;
        end
        if (io_req.re && io_req.addr == `TIC_A_CNT_LO) begin
            n.temp = r.cnt[15:8];
        end
        if (io_req.re && io_req.addr == `TIC_A_CAP_LO) begin
            n.temp = r.cap[15:8];
        end
        if (io_req.we && (io_req.addr == `TIC_A_CNT_HI ||
                          io_req.addr == `TIC_A_CAP_HI)) begin
            n.temp = io_req.wdata;
        end

        if (io_req.we && io_req.addr == `TIC_A_CTRL) begin
            n.ctrl = io_req.wdata & `TIC_CTRL_WMASK;
        end
        if (io_req.we && io_req.addr == `TIC_A_MASK) begin
            n.mask = io_req.wdata & `TIC_MASK_WMASK;
        end

        if (wr_cnt) begin
            n.cnt = {r.temp, io_req.wdata};
        end else if (top_hit) begin
            n.cnt = `TIC_RST_WORD;
        end else if (tick) begin
            n.cnt = r.cnt + 16'h0001;
        end

        // Match of the next tick is removed after a counter write
        if (wr_cnt) begin
            n.block = 1'h1;
        end else if (tick) begin
            n.block = 1'h0;
        end

        if (cap_evt) begin
            n.cap = r.cnt;
        end else if (wr_cap && clear_on_match_mode) begin
            n.cap = {r.temp, io_req.wdata};
        end

        // Set beats clear in the same cycle
        n.cflag = cap_evt | top_hit | (r.cflag & ~cf_clr);
        n.oflag = ovf_hit | (r.oflag & ~of_clr);

        n.irq_c = r.mask[`TIC_B_CIE] & global_irq_en & r.cflag;
        n.irq_o = r.mask[`TIC_B_OIE] & global_irq_en & r.oflag;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.ctrl <= `TIC_RST_CTRL;
            r.mask <= `TIC_RST_MASK;
            r.cnt <= `TIC_RST_WORD;
            r.cap <= `TIC_RST_WORD;
        end else begin
            r <= n;
        end
    end

    assign io_rdata = r.rdata;
    assign capture_irq = r.irq_c;
    assign overflow_irq = r.irq_o;
    assign compare_block = r.block;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_cnt_wr;
        io_req.we && io_req.addr == `TIC_A_CNT_LO;
    endsequence

    sequence s_lo_read;
        io_req.re && io_req.addr == `TIC_A_CNT_LO;
    endsequence

    sequence s_hi_read;
        io_req.re && io_req.addr == `TIC_A_CNT_HI && !io_req.we;
    endsequence

    sequence s_filt_arm;
        r.ctrl[`TIC_B_NF] && r.ctrl[`TIC_B_EDGE] && !clear_on_match_mode &&
        !r.filt && !r.edge_prev && r.hist == 4'h0 && src;
    endsequence

    a_cnt_commit: assert property (s_cnt_wr |=>
        r.cnt == {$past(r.temp), $past(io_req.wdata)})
        else $error("counter low write did not commit both bytes");

    a_block_set: assert property (s_cnt_wr |=> compare_block)
        else $error("compare block not raised after counter write");

    a_hi_latch: assert property (s_lo_read ##1 s_hi_read |=>
        io_rdata == $past(cnt_hi, 2))
        else $error("high byte read did not return latched value");

    a_ovf_wrap: assert property (ovf_hit && !top_hit |=>
        r.oflag && r.cnt == 16'h0000)
        else $error("wrap did not set overflow and clear counter");

    a_top_clear: assert property (top_hit |=>
        r.cnt == 16'h0000 && r.cflag)
        else $error("top match did not clear counter and flag");

    a_capture_copy: assert property (cap_evt |=>
        r.cap == $past(r.cnt) && r.cflag)
        else $error("capture did not copy counter");

    a_ctc_nocap: assert property (clear_on_match_mode && !wr_cap |=>
        r.cap == $past(r.cap))
        else $error("capture register changed while it is top");

    a_stop_hold: assert property (cs == `TIC_CS_STOP && !wr_cnt |=>
        r.cnt == $past(r.cnt))
        else $error("stopped counter moved");

    a_filt_hold: assert property (r.ctrl[`TIC_B_NF] && !hist_eq |=>
        r.filt == $past(r.filt))
        else $error("filter output changed without four equal samples");

    a_filt_delay: assert property (s_filt_arm ##1
        (src && r.ctrl[`TIC_B_NF] && !clear_on_match_mode)[*3] |-> ##2 cap_evt)
        else $error("filtered capture not five cycles after the change");

    a_irq_cap: assert property (r.mask[`TIC_B_CIE] && global_irq_en &&
        r.cflag |=> capture_irq)
        else $error("capture interrupt not requested");

    a_irq_ovf: assert property (!r.mask[`TIC_B_OIE] |=>
        !overflow_irq)
        else $error("overflow interrupt while disabled");

    a_cf_clear: assert property (capture_ack && !cap_evt && !top_hit |=>
        !r.cflag)
        else $error("capture flag not cleared");

    a_of_clear: assert property (overflow_ack && !ovf_hit |=> !r.oflag)
        else $error("overflow flag not cleared");

    a_rsv_zero: assert property (io_req.re &&
        (io_req.addr == `TIC_A_MASK || io_req.addr == `TIC_A_FLAGS)
        |=> io_rdata[7:6] == 2'h0)
        else $error("unused mask or flag bits read nonzero");

endmodule

// >>> test/tic_core_model.sv
// Processor core side: byte register accesses and vector acknowledges
`timescale 1ns/1ps
module tic_core_model (
    input wire logic core_clk,
    input wire logic [7:0] io_rdata,
    output tic_pkg::tic_io_req_t io_req,
    output logic capture_ack,
    output logic overflow_ack
);
    import tic_pkg::*;
    initial begin
        io_req = '0;
        capture_ack = 1'b0;
        overflow_ack = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        io_req.we = 1'b1;
        io_req.addr = a;
        io_req.wdata = d;
        @(posedge core_clk);
        #1;
        io_req.we = 1'b0;
        // Released data shows garbage, not the last byte
        io_req.wdata = ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        io_req.re = 1'b1;
        io_req.addr = a;
        @(posedge core_clk);
        #1;
        io_req.re = 1'b0;
        @(posedge core_clk);
        #1;
        d = io_rdata;
    endtask
    task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
        wr(lo + 3'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    // Low then high byte on back to back cycles, strobe held up
    task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
        @(posedge core_clk);
        #1;
        io_req.re = 1'b1;
        io_req.addr = lo;
        @(posedge core_clk);
        #1;
        v[7:0] = io_rdata;
        io_req.addr = lo + 3'h1;
        @(posedge core_clk);
        #1;
        io_req.re = 1'b0;
        v[15:8] = io_rdata;
    endtask
    task automatic ack(input logic cap);
        @(posedge core_clk);
        #1;
        capture_ack = cap;
        overflow_ack = ~cap;
        @(posedge core_clk);
        #1;
        capture_ack = 1'b0;
        overflow_ack = 1'b0;
    endtask
endmodule

// >>> test/tic_timer_tb.sv
// Bench for the sixteen bit timer with input capture
`timescale 1ns/1ps
`include "tic_map.svh"
`define CHK(a, e) begin \
    checked++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module tic_timer_tb;
    import tic_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cpin = 1'b0;
    logic epin = 1'b0;
    logic gie = 1'b0;
    logic acmp = 1'b0;
    logic asel = 1'b0;
    logic [7:0] io_rdata;
    tic_io_req_t io_req;
    logic cack, oack, cirq, oirq, cblk;
    logic [7:0] b;
    logic [15:0] w;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    always #25 core_clk = ~core_clk;
    tic_core_model CORE (.core_clk(core_clk), .io_rdata(io_rdata),
        .io_req(io_req), .capture_ack(cack), .overflow_ack(oack));
    tic_timer DUT (.core_clk(core_clk), .rstn(rstn), .io_req(io_req),
        .io_rdata(io_rdata), .global_irq_en(gie), .capture_ack(cack),
        .overflow_ack(oack), .capture_input_pin(cpin), .acomp_out(acmp),
        .acomp_capture_sel(asel), .external_count_pin(epin),
        .capture_irq(cirq), .overflow_irq(oirq), .compare_block(cblk));
    task automatic results();
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end
    initial begin
        tick(12);
        rstn = 1'b1;
        CORE.rd(`TIC_A_CTRL, b);
        `CHK(b, `TIC_RST_CTRL)
        CORE.wr(`TIC_A_MASK, 8'hff);
        CORE.rd(`TIC_A_MASK, b);
        `CHK(b, 8'h21)
        CORE.rd(`TIC_A_FLAGS, b);
        `CHK(b, 8'h00)
        CORE.rd(3'h7, b);
        `CHK(b, 8'h00)
        CORE.wr16(`TIC_A_CNT_LO, 16'h12fe);
        CORE.wr(`TIC_A_CTRL, 8'h02);
        tick(5);
        CORE.rd16(`TIC_A_CNT_LO, w);
        `CHK(w, 16'h12fe)
        `CHK(cblk, 1'b1)
        // Rising capture with the counter held still
        gie = 1'b1;
        CORE.wr(`TIC_A_CTRL, 8'h40);
        cpin = 1'b1;
        tick(6);
        `CHK(cirq, 1'b1)
        CORE.rd16(`TIC_A_CAP_LO, w);
        `CHK(w, 16'h12fe)
        CORE.wr(`TIC_A_FLAGS, 8'h20);
        CORE.rd(`TIC_A_FLAGS, b);
        `CHK(b, 8'h00)
        cpin = 1'b0;
        tick(6);
        `CHK(cirq, 1'b0)
        // Filtered falling capture: short glitch ignored
        CORE.wr(`TIC_A_CTRL, 8'h80);
        cpin = 1'b1;
        tick(8);
        cpin = 1'b0;
        tick(3);
        cpin = 1'b1;
        tick(8);
        `CHK(cirq, 1'b0)
        cpin = 1'b0;
        tick(4);
        `CHK(cirq, 1'b0)
        tick(5);
        `CHK(cirq, 1'b1)
        CORE.ack(1'b1);
        tick(2);
        `CHK(cirq, 1'b0)
        // Comparator as capture source, pin ignored
        CORE.wr(`TIC_A_CTRL, 8'h40);
        asel = 1'b1;
        cpin = 1'b1;
        tick(4);
        `CHK(cirq, 1'b0)
        acmp = 1'b1;
        tick(4);
        `CHK(cirq, 1'b1)
        acmp = 1'b0;
        asel = 1'b0;
        cpin = 1'b0;
        tick(2);
        CORE.wr(`TIC_A_FLAGS, 8'h20);
        // External count pin, rising then falling edges
        CORE.wr16(`TIC_A_CNT_LO, 16'h0000);
        CORE.wr(`TIC_A_CTRL, 8'h07);
        for (int i = 0; i < 5; i++) begin
            if (i == 3) begin
                CORE.wr(`TIC_A_CTRL, 8'h06);
            end
            epin = 1'b1;
            tick(2);
            epin = 1'b0;
            tick(2);
        end
        CORE.rd16(`TIC_A_CNT_LO, w);
        `CHK(w, 16'h0005)
        `CHK(cblk, 1'b0)
        // Wrap to zero raises the overflow flag
        CORE.wr(`TIC_A_CTRL, 8'h00);
        gie = 1'b0;
        CORE.wr16(`TIC_A_CNT_LO, 16'hfffd);
        CORE.wr(`TIC_A_CTRL, 8'h01);
        tick(10);
        `CHK(oirq, 1'b0)
        CORE.rd(`TIC_A_FLAGS, b);
        `CHK(b, 8'h01)
        gie = 1'b1;
        tick(3);
        `CHK(oirq, 1'b1)
        CORE.wr(`TIC_A_FLAGS, 8'h01);
        tick(2);
        `CHK(oirq, 1'b0)
        // Second wrap, cleared by the vector acknowledge
        CORE.wr16(`TIC_A_CNT_LO, 16'hfffd);
        tick(6);
        `CHK(oirq, 1'b1)
        CORE.ack(1'b0);
        tick(2);
        `CHK(oirq, 1'b0)
        // Clear-on-match with the capture word as top
        CORE.wr(`TIC_A_CTRL, 8'h10);
        CORE.wr16(`TIC_A_CNT_LO, 16'h0000);
        CORE.wr16(`TIC_A_CAP_LO, 16'h0005);
        CORE.wr(`TIC_A_CTRL, 8'h11);
        // Pin falls while the count is 2, so a capture of 3 would show
        cpin = 1'b1;
        tick(2);
        cpin = 1'b0;
        tick(20);
        CORE.rd(`TIC_A_FLAGS, b);
        `CHK(b, 8'h20)
        CORE.rd16(`TIC_A_CAP_LO, w);
        `CHK(w, 16'h0005)
        CORE.rd16(`TIC_A_CNT_LO, w);
        `CHK(w <= 16'h0005, 1'b1)
        results();
    end
endmodule
